// ===== dpa_pkg.sv
// dpa_pkg: shared constants for the dual port parallel adapter
package dpa_pkg;
    // register select codes (reg_pick_bit1, reg_pick_bit0)
    localparam logic [1:0] DPA_RS_PORT_A = 2'h0;
    localparam logic [1:0] DPA_RS_CTRL_A = 2'h1;
    localparam logic [1:0] DPA_RS_PORT_B = 2'h2;
    localparam logic [1:0] DPA_RS_CTRL_B = 2'h3;
    // control register field positions
    localparam int DPA_CR_FLAG1    = 7;
    localparam int DPA_CR_FLAG2    = 6;
    localparam int DPA_CR_L2_MODE  = 5;
    localparam int DPA_CR_L2_SEL   = 4;
    localparam int DPA_CR_L2_CTL   = 3;
    localparam int DPA_CR_DIR_ACC  = 2;
    localparam int DPA_CR_EDGE1    = 1;
    localparam int DPA_CR_IRQ1_EN  = 0;
    // writable part of the control register (flags are hardware owned)
    localparam logic [7:0] DPA_CR_WR_MASK = 8'h3F;
    // reset values
    localparam logic [7:0] DPA_CTRL_RST = 8'h00;
    localparam logic [7:0] DPA_DIR_RST  = 8'h00;
    localparam logic [7:0] DPA_OUT_RST  = 8'h00;
    localparam logic [7:0] DPA_HOLD_RST = 8'h00;
    // port width
    localparam int DPA_PORT_W = 8;
endpackage

// ===== dpa_side.sv
// dpa_side: control register, flags and control lines for one side
`timescale 1ns/1ps
`default_nettype none
module dpa_side import dpa_pkg::*; #(
    parameter bit IS_B = 1'b0                 // side b pulses on write, side a on read
) (
    input  wire logic       clk_in,           // system clock
    input  wire logic       rst_in,           // combined synchronous reset
    input  wire logic       strobe_fall_in,   // end of an enable strobe
    input  wire logic       ctrl_wr_in,       // control register write pulse
    input  wire logic [7:0] wr_data_in,       // holding latch contents
    input  wire logic       port_rd_in,       // port data read completed
    input  wire logic       port_wr_in,       // output latch written
    input  wire logic       edge_in,          // first control input
    input  wire logic       line_in,          // second control line, input level
    output logic      [7:0] ctrl_out,         // control register value
    output logic            irq_out,          // request active
    output logic            line_out,         // second control line output level
    output logic            line_oe_out       // second control line driven
);
    logic [5:0] cfg_reg;
    logic       flag1_reg;
    logic       flag2_reg;
    logic       edge_prev_reg;
    logic       line_prev_reg;
    logic       irq_reg;
    logic       line_reg;
    logic       oe_reg;
    logic       act1;
    logic       act2;
    logic       trig;
    logic       out_mode;
    logic       irq_next;
    logic       line_next;

    // active transitions, polarity from control bits 1 and 4
    assign act1     = cfg_reg[DPA_CR_EDGE1] ? (~edge_prev_reg & edge_in)
                                            : (edge_prev_reg & ~edge_in);      // R19
    assign act2     = cfg_reg[DPA_CR_L2_SEL] ? (~line_prev_reg & line_in)
                                             : (line_prev_reg & ~line_in);     // R20
    assign out_mode = cfg_reg[DPA_CR_L2_MODE];
    assign trig     = IS_B ? port_wr_in : port_rd_in;                          // R23
    // bit 3 doubles as the second flag's enable while the line is an input
    assign irq_next = (flag1_reg & cfg_reg[DPA_CR_IRQ1_EN])
                    | (flag2_reg & ~out_mode & cfg_reg[DPA_CR_L2_CTL]);        // R17
    // output level of the second line per mode
    assign line_next = ~out_mode ? 1'b1 :
                       cfg_reg[DPA_CR_L2_SEL] ? cfg_reg[DPA_CR_L2_CTL] :       // R21
                       trig ? 1'b0 :                                           // R23
                       (cfg_reg[DPA_CR_L2_CTL] & strobe_fall_in) ? 1'b1 :
                       (~cfg_reg[DPA_CR_L2_CTL] & act1) ? 1'b1 : line_reg;

    // configuration bits, only software writes them
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_reg <= DPA_CTRL_RST[5:0];                                      // R15
        end else if (ctrl_wr_in) begin
            cfg_reg <= wr_data_in[5:0];                                        // R02
        end
    end

    // flags: a set in the same cycle as a clearing read wins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag1_reg <= 1'b0;
            flag2_reg <= 1'b0;
        end else begin
            flag1_reg <= act1 | (flag1_reg & ~port_rd_in);                     // R19 R22
            flag2_reg <= ~out_mode & (act2 | (flag2_reg & ~port_rd_in));       // R20 R22
        end
    end

    // edge history, request and line outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            edge_prev_reg <= 1'b0;
            line_prev_reg <= 1'b0;
            irq_reg       <= 1'b0;
            line_reg      <= 1'b1;
            oe_reg        <= 1'b0;
        end else begin
            edge_prev_reg <= edge_in;
            line_prev_reg <= line_in;
            irq_reg       <= irq_next;                                         // R16
            line_reg      <= line_next;
            oe_reg        <= out_mode;
        end
    end

    assign ctrl_out    = {flag1_reg, flag2_reg, cfg_reg};                      // R18
    assign irq_out     = irq_reg;
    assign line_out    = line_reg;
    assign line_oe_out = oe_reg;
endmodule // dpa_side
`default_nettype wire

// ===== dpa_adapter.sv
// dpa_adapter: processor bus front end, six registers and both peripheral ports
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: two mirrored sides a and b, each with control, direction, output latch, port.
// R02: writes pass through a holding latch before reaching the addressed register.
// R03: control bit 2 picks output latch (1) or direction register (0).
// R04: select 00 port a, 01 control a, 10 port b, 11 control b.
// R05: each direction bit makes its line input (0) or output (1).
// R06: an output line drives its output latch bit, low for 0, high for 1.
// R07: output latch bits do not affect input lines; mixed ports allowed.
// R08: access only when both high selects are high and the low select is low.
// R09: read/write low writes into the device, high reads from it.
// R10: the enable strobe alone times every register transfer.
// R11: data bus drivers are off except during a selected read.
// R12: all six registers writable; control and direction read back stored values.
// R13: side a port read returns sampled pin levels on every line.
// R14: side b port read returns latch bits for outputs, pins for inputs.
// R15: active low clear resets every register to zero.
// R16: one active low request per side, pull low only, wired-or capable.
// R17: control bits 7 and 6 are flags, each with its own request enable.
// R18: control layout 7 flag1, 6 flag2, 5..3 line2, 2 access, 1..0 line1.
// R19: bit 1 selects first input edge; edge sets bit 7; bit 0 enables request.
// R20: with bit 5 clear, second line edge chosen by bit 4 sets bit 6.
// R21: with bits 5 and 4 set, second line statically follows bit 3.
// R22: reading a side's port data clears both its flags.
// R23: pulse and handshake output modes; side a on read, side b on write.
module dpa_adapter import dpa_pkg::*; #(
    parameter int PORT_W = DPA_PORT_W                  // peripheral port width
) (
    input  wire logic              clk_in,             // 250 mhz system clock
    input  wire logic              sys_rst_in,         // synchronous reset, active high
    input  wire logic              clear_all_n_in,     // device clear, active low
    input  wire logic              enable_in,          // bus timing strobe
    input  wire logic              read_not_write_in,  // 1 read, 0 write
    input  wire logic              select_high_first_in,   // chip select, active high
    input  wire logic              select_high_second_in,  // chip select, active high
    input  wire logic              select_low_n_in,    // chip select, active low
    input  wire logic              reg_pick_bit0_in,   // register select bit 0
    input  wire logic              reg_pick_bit1_in,   // register select bit 1
    input  wire logic [7:0]        host_data_bus_in,   // data bus level
    output logic      [7:0]        host_data_bus_out,  // data bus drive value
    output logic                   host_data_bus_oe_out,   // data bus drive enable
    output logic                   int_request_a_n_out,    // side a request, always 0
    output logic                   int_request_a_n_oe_out, // side a request pulls low
    output logic                   int_request_b_n_out,    // side b request, always 0
    output logic                   int_request_b_n_oe_out, // side b request pulls low
    input  wire logic [PORT_W-1:0] port_side_a_lines_in,   // side a pin levels
    output logic      [PORT_W-1:0] port_side_a_lines_out,  // side a drive values
    output logic      [PORT_W-1:0] port_side_a_lines_oe_out, // side a drive enables
    input  wire logic [PORT_W-1:0] port_side_b_lines_in,   // side b pin levels
    output logic      [PORT_W-1:0] port_side_b_lines_out,  // side b drive values
    output logic      [PORT_W-1:0] port_side_b_lines_oe_out, // side b drive enables
    input  wire logic              side_a_edge_input_in,   // side a first control input
    input  wire logic              side_a_control_line_in, // side a second line level
    output logic                   side_a_control_line_out,    // side a second line value
    output logic                   side_a_control_line_oe_out, // side a second line driven
    input  wire logic              side_b_edge_input_in,   // side b first control input
    input  wire logic              side_b_control_line_in, // side b second line level
    output logic                   side_b_control_line_out,    // side b second line value
    output logic                   side_b_control_line_oe_out  // side b second line driven
);
    logic [7:0]        hold_reg;
    logic [PORT_W-1:0] direction_side_a;
    logic [PORT_W-1:0] direction_side_b;
    logic [PORT_W-1:0] output_latch_side_a;
    logic [PORT_W-1:0] output_latch_side_b;
    logic              en_prev_reg;
    logic              acc_reg;
    logic              acc_rd_reg;
    logic [1:0]        acc_rs_reg;
    logic [7:0]        dout_reg;
    logic              doe_reg;
    logic              zero_reg;

    logic              rst;
    logic              selected;
    logic              rd_active;
    logic              wr_active;
    logic              strobe_fall;
    logic [1:0]        rs_now;
    logic [7:0]        ctrl_a;
    logic [7:0]        ctrl_b;
    logic              irq_a;
    logic              irq_b;
    logic              wr_done;
    logic              rd_done;
    logic              wr_port_a;
    logic              wr_dir_a;
    logic              wr_port_b;
    logic              wr_dir_b;
    logic              wr_ctrl_a;
    logic              wr_ctrl_b;
    logic              rd_port_a;
    logic              rd_port_b;
    logic [7:0]        pins_a;
    logic [7:0]        pins_b;
    logic [7:0]        rd_mux;

    // picks the port word or direction word according to the access bit
    function automatic logic [7:0] pick_port(input logic acc_bit,
                                             input logic [7:0] port_word,
                                             input logic [7:0] dir_word);
        pick_port = acc_bit ? port_word : dir_word;
    endfunction

    // either reset source clears everything; clear is sampled, not asynchronous
    assign rst = sys_rst_in | ~clear_all_n_in;                                   // R15

    // bus decode
    assign selected  = select_high_first_in & select_high_second_in & ~select_low_n_in; // R08
    assign rs_now    = {reg_pick_bit1_in, reg_pick_bit0_in};
    assign rd_active = selected & enable_in & read_not_write_in;                 // R09
    assign wr_active = selected & enable_in & ~read_not_write_in;                // R09
    // transfers complete on the falling edge of the strobe
    assign strobe_fall = en_prev_reg & ~enable_in;                               // R10
    assign wr_done     = strobe_fall & acc_reg & ~acc_rd_reg;
    assign rd_done     = strobe_fall & acc_reg & acc_rd_reg;

    // write targets: register select plus the side's access bit
    assign wr_ctrl_a = wr_done & (acc_rs_reg == DPA_RS_CTRL_A);                  // R04
    assign wr_ctrl_b = wr_done & (acc_rs_reg == DPA_RS_CTRL_B);                  // R04
    assign wr_port_a = wr_done & (acc_rs_reg == DPA_RS_PORT_A) & ctrl_a[DPA_CR_DIR_ACC]; // R03
    assign wr_dir_a  = wr_done & (acc_rs_reg == DPA_RS_PORT_A) & ~ctrl_a[DPA_CR_DIR_ACC];
    assign wr_port_b = wr_done & (acc_rs_reg == DPA_RS_PORT_B) & ctrl_b[DPA_CR_DIR_ACC]; // R03
    assign wr_dir_b  = wr_done & (acc_rs_reg == DPA_RS_PORT_B) & ~ctrl_b[DPA_CR_DIR_ACC];
    // port data reads clear the flags of their side
    assign rd_port_a = rd_done & (acc_rs_reg == DPA_RS_PORT_A) & ctrl_a[DPA_CR_DIR_ACC]; // R22
    assign rd_port_b = rd_done & (acc_rs_reg == DPA_RS_PORT_B) & ctrl_b[DPA_CR_DIR_ACC]; // R22

    // read-back words; side b masks loaded output pins with the latch
    assign pins_a = port_side_a_lines_in;                                        // R13
    assign pins_b = (direction_side_b & output_latch_side_b)
                  | (~direction_side_b & port_side_b_lines_in);                  // R14
    assign rd_mux = (rs_now == DPA_RS_CTRL_A) ? ctrl_a :                         // R12
                    (rs_now == DPA_RS_CTRL_B) ? ctrl_b :
                    (rs_now == DPA_RS_PORT_A) ?
                        pick_port(ctrl_a[DPA_CR_DIR_ACC], pins_a, direction_side_a) :
                        pick_port(ctrl_b[DPA_CR_DIR_ACC], pins_b, direction_side_b);

    // strobe history; access attributes sampled while the strobe is high, held once it falls
    always_ff @(posedge clk_in) begin
        if (rst) begin
            en_prev_reg <= 1'b0;
            acc_reg     <= 1'b0;
            acc_rd_reg  <= 1'b0;
            acc_rs_reg  <= DPA_RS_PORT_A;
        end else begin
            en_prev_reg <= enable_in;
            if (enable_in) begin
                acc_reg    <= selected;                                          // R08
                acc_rd_reg <= read_not_write_in;
                acc_rs_reg <= rs_now;
            end
        end
    end

    // holding latch follows the bus during a write strobe
    always_ff @(posedge clk_in) begin
        if (rst) begin
            hold_reg <= DPA_HOLD_RST;
        end else if (wr_active) begin
            hold_reg <= host_data_bus_in;                                        // R02
        end
    end

    // direction and output latches take the held byte at strobe end, so pins move once
    always_ff @(posedge clk_in) begin
        if (rst) begin
            direction_side_a    <= DPA_DIR_RST;                                  // R15
            direction_side_b    <= DPA_DIR_RST;
            output_latch_side_a <= DPA_OUT_RST;
            output_latch_side_b <= DPA_OUT_RST;
        end else begin
            if (wr_dir_a)  direction_side_a    <= hold_reg;                      // R02
            if (wr_dir_b)  direction_side_b    <= hold_reg;
            if (wr_port_a) output_latch_side_a <= hold_reg;
            if (wr_port_b) output_latch_side_b <= hold_reg;
        end
    end

    // read data is registered; bus drives only during a selected read strobe
    always_ff @(posedge clk_in) begin
        if (rst) begin
            dout_reg <= 8'h00;
            doe_reg  <= 1'b0;
            zero_reg <= 1'b0;
        end else begin
            dout_reg <= rd_active ? rd_mux : 8'h00;
            doe_reg  <= rd_active;                                               // R11
            zero_reg <= 1'b0;
        end
    end

    dpa_side #(.IS_B(1'b0)) u_side_a ( // R01
        .clk_in         (clk_in),
        .rst_in         (rst),
        .strobe_fall_in (strobe_fall),
        .ctrl_wr_in     (wr_ctrl_a),
        .wr_data_in     (hold_reg),
        .port_rd_in     (rd_port_a),
        .port_wr_in     (wr_port_a),
        .edge_in        (side_a_edge_input_in),
        .line_in        (side_a_control_line_in),
        .ctrl_out       (ctrl_a),
        .irq_out        (irq_a),
        .line_out       (side_a_control_line_out),
        .line_oe_out    (side_a_control_line_oe_out)
    );

    dpa_side #(.IS_B(1'b1)) u_side_b ( // R01
        .clk_in         (clk_in),
        .rst_in         (rst),
        .strobe_fall_in (strobe_fall),
        .ctrl_wr_in     (wr_ctrl_b),
        .wr_data_in     (hold_reg),
        .port_rd_in     (rd_port_b),
        .port_wr_in     (wr_port_b),
        .edge_in        (side_b_edge_input_in),
        .line_in        (side_b_control_line_in),
        .ctrl_out       (ctrl_b),
        .irq_out        (irq_b),
        .line_out       (side_b_control_line_out),
        .line_oe_out    (side_b_control_line_oe_out)
    );

    // outputs come straight from flops; ports drive latch values where direction is 1
    assign host_data_bus_out        = dout_reg;
    assign host_data_bus_oe_out     = doe_reg;
    assign port_side_a_lines_out    = output_latch_side_a;                       // R06
    assign port_side_a_lines_oe_out = direction_side_a;                          // R05 R07
    assign port_side_b_lines_out    = output_latch_side_b;                       // R06
    assign port_side_b_lines_oe_out = direction_side_b;                          // R05 R07
    // requests only ever pull low, so both may share one wired-or net
    assign int_request_a_n_out      = zero_reg;                                  // R16
    assign int_request_a_n_oe_out   = irq_a;
    assign int_request_b_n_out      = zero_reg;
    assign int_request_b_n_oe_out   = irq_b;

    // checks on the bus sequence and the register effects
    sequence s_write_end;
        strobe_fall && acc_reg && !acc_rd_reg;
    endsequence

    sequence s_read_strobe;
        selected && enable_in && read_not_write_in;
    endsequence

    bus_drive_window_a: assert property (@(posedge clk_in) disable iff (rst) // R11
        host_data_bus_oe_out |-> $past(rd_active))
        else $error("data bus driven outside a selected read");

    read_drive_start_a: assert property (@(posedge clk_in) disable iff (rst) // R09
        s_read_strobe |=> host_data_bus_oe_out)
        else $error("selected read did not drive the bus");

    dir_write_a: assert property (@(posedge clk_in) disable iff (rst) // R03
        (s_write_end and (acc_rs_reg == DPA_RS_PORT_A && !ctrl_a[DPA_CR_DIR_ACC]))
        |=> port_side_a_lines_oe_out == $past(hold_reg))
        else $error("direction write on side a not taken");

    latch_write_b_a: assert property (@(posedge clk_in) disable iff (rst) // R04
        (s_write_end and (acc_rs_reg == DPA_RS_PORT_B && ctrl_b[DPA_CR_DIR_ACC]))
        |=> port_side_b_lines_out == $past(hold_reg))
        else $error("output latch write on side b not taken");

    unselected_quiet_a: assert property (@(posedge clk_in) disable iff (rst) // R08
        (enable_in && !selected) ##1 strobe_fall |=> $stable(direction_side_a)
            && $stable(output_latch_side_a) && $stable(ctrl_a[5:0]))
        else $error("register changed without chip select");

    side_b_readback_a: assert property (@(posedge clk_in) disable iff (rst) // R14
        (s_read_strobe and (rs_now == DPA_RS_PORT_B && ctrl_b[DPA_CR_DIR_ACC]))
        |=> host_data_bus_out == $past((direction_side_b & output_latch_side_b)
                                     | (~direction_side_b & port_side_b_lines_in)))
        else $error("side b read-back mixes pins and latch wrongly");

    side_a_readback_a: assert property (@(posedge clk_in) disable iff (rst) // R13
        (s_read_strobe and (rs_now == DPA_RS_PORT_A && ctrl_a[DPA_CR_DIR_ACC]))
        |=> host_data_bus_out == $past(port_side_a_lines_in))
        else $error("side a read-back is not the pin levels");

    clear_zero_a: assert property (@(posedge clk_in) // R15
        !clear_all_n_in |=> (direction_side_a == 8'h00) && (output_latch_side_b == 8'h00)
            && (ctrl_a == 8'h00) && (ctrl_b == 8'h00) && !host_data_bus_oe_out)
        else $error("clear did not zero the registers");

    flag_edge_a: assert property (@(posedge clk_in) disable iff (rst) // R19
        (ctrl_a[DPA_CR_EDGE1] && $rose(side_a_edge_input_in)) |=> ctrl_a[DPA_CR_FLAG1])
        else $error("active edge did not set the first flag");

    flag_clear_a: assert property (@(posedge clk_in) disable iff (rst) // R22
        (rd_port_a && !$changed(side_a_edge_input_in)) |=> !ctrl_a[DPA_CR_FLAG1])
        else $error("port read did not clear the first flag");

    request_gate_a: assert property (@(posedge clk_in) disable iff (rst) // R17
        int_request_a_n_oe_out |-> $past(ctrl_a[DPA_CR_FLAG1] && ctrl_a[DPA_CR_IRQ1_EN]
            || ctrl_a[DPA_CR_FLAG2] && ctrl_a[DPA_CR_L2_CTL] && !ctrl_a[DPA_CR_L2_MODE]))
        else $error("side a request without an enabled flag");

    static_line_a: assert property (@(posedge clk_in) disable iff (rst) // R21
        (ctrl_b[DPA_CR_L2_MODE] && ctrl_b[DPA_CR_L2_SEL]) [*2]
        |-> side_b_control_line_oe_out && side_b_control_line_out == $past(ctrl_b[DPA_CR_L2_CTL]))
        else $error("static second line does not follow bit 3");

    // second line input mirrors the first
    flag2_edge_a: assert property (@(posedge clk_in) disable iff (rst) // R20
        (!ctrl_a[DPA_CR_L2_MODE] && !ctrl_a[DPA_CR_L2_SEL]
            && $fell(side_a_control_line_in))
        |=> ctrl_a[DPA_CR_FLAG2])
        else $error("second line edge did not set its flag");

    // a port read starts the pulse on side a
    pulse_read_a: assert property (@(posedge clk_in) disable iff (rst) // R23
        (ctrl_a[DPA_CR_L2_MODE] && !ctrl_a[DPA_CR_L2_SEL] && rd_port_a)
        |=> !side_a_control_line_out)
        else $error("port read did not pull the second line low");

    // requests never drive high
    request_low_a: assert property (@(posedge clk_in) disable iff (rst) // R16
        !int_request_a_n_out && !int_request_b_n_out)
        else $error("request output not held low");

    flag_clear_b_a: assert property (@(posedge clk_in) disable iff (rst) // R22
        (rd_port_b && !$changed(side_b_edge_input_in)) |=> !ctrl_b[DPA_CR_FLAG1])
        else $error("side b flag not cleared by read");
endmodule // dpa_adapter
`default_nettype wire

// ===== dpa_host_model.sv
// dpa_host_model: processor side data bus net and shared request line
`timescale 1ns/1ps
`default_nettype none
module dpa_host_model (
    input  wire logic       clk_in,      // system clock
    input  wire logic [7:0] dev_drv_in,  // adapter drive value
    input  wire logic       dev_oe_in,   // adapter drives the bus
    input  wire logic [7:0] cpu_drv_in,  // processor write data
    input  wire logic       cpu_oe_in,   // processor drives the bus
    input  wire logic       req_a_oe_in, // side a pulls the request low
    input  wire logic       req_b_oe_in, // side b pulls the request low
    output logic      [7:0] bus_out,     // resolved bus level
    output logic            irq_n_out    // shared request net
);
    // a released bus keeps changing so a stale byte never reads as valid
    logic [7:0] float_reg;
    always_ff @(posedge clk_in) float_reg <= ~bus_out;
    assign bus_out = dev_oe_in ? dev_drv_in : (cpu_oe_in ? cpu_drv_in : float_reg);
    // pull-up resistor: either side may only pull the net low
    assign irq_n_out = ~(req_a_oe_in | req_b_oe_in);
endmodule // dpa_host_model
`default_nettype wire

// ===== dual_port_parallel_adapter_tb_top.sv
// dual_port_parallel_adapter_tb_top: self-checking bench for the adapter
`timescale 1ns/1ps
`default_nettype none
module dual_port_parallel_adapter_tb_top;
    import dpa_pkg::*;
    logic clk = 0, rst = 1, clr_n = 1, en = 0, rnw = 1, cs_n = 0, e_a = 0, e_b = 0, w_oe = 0;
    logic oe, qa, qb, la, lae, lb, lbe, irq_n;
    logic [1:0] cs_h = 2'h3, ln = 2'h3, zq;
    logic [1:0] rs = 2'h0;
    logic [7:0] wd = 8'h00, bus, dout, pa = 8'h00, pb = 8'h00, pa_o, pa_e, pb_o, pb_e;
    int err_total = 0, cmp_count = 0, seed = 32'hebfbba49, k, s, dir[2], lat[2];
    always #2 clk = ~clk;
    dpa_host_model HOST (.clk_in(clk), .dev_drv_in(dout), .dev_oe_in(oe), .cpu_drv_in(wd), .cpu_oe_in(w_oe),
        .req_a_oe_in(qa), .req_b_oe_in(qb), .bus_out(bus), .irq_n_out(irq_n));
    dpa_adapter DUT (.clk_in(clk), .sys_rst_in(rst), .clear_all_n_in(clr_n), .enable_in(en),
        .read_not_write_in(rnw), .select_high_first_in(cs_h[0]), .select_high_second_in(cs_h[1]),
        .select_low_n_in(cs_n), .reg_pick_bit0_in(rs[0]), .reg_pick_bit1_in(rs[1]), .host_data_bus_in(bus),
        .host_data_bus_out(dout), .host_data_bus_oe_out(oe), .int_request_a_n_out(zq[0]),
        .int_request_a_n_oe_out(qa), .int_request_b_n_out(zq[1]), .int_request_b_n_oe_out(qb),
        .port_side_a_lines_in(pa), .port_side_a_lines_out(pa_o), .port_side_a_lines_oe_out(pa_e),
        .port_side_b_lines_in(pb), .port_side_b_lines_out(pb_o), .port_side_b_lines_oe_out(pb_e),
        .side_a_edge_input_in(e_a), .side_a_control_line_in(ln[0]), .side_a_control_line_out(la),
        .side_a_control_line_oe_out(lae), .side_b_edge_input_in(e_b), .side_b_control_line_in(ln[1]),
        .side_b_control_line_out(lb), .side_b_control_line_oe_out(lbe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // expected port read-back per side
    function automatic logic [7:0] pexp(input int sd);
        return sd ? 8'((dir[1] & lat[1]) | (~dir[1] & pb)) : pa;
    endfunction
    // one write: strobe, release, then two edges for the transfer to land
    task automatic wr(input logic [1:0] r, input logic [7:0] d);
        @(negedge clk) {rs, rnw, wd, w_oe, en} = {r, 1'h0, d, 2'h3};
        @(negedge clk) en = 0;
        @(negedge clk) {w_oe, rnw} = 2'h1;
        @(negedge clk);
    endtask
    // one read: data valid one edge into the strobe, bus released after it
    task automatic rd(input logic [1:0] r, input logic [7:0] exp);
        @(negedge clk) {rs, rnw, en} = {r, 2'h3};
        @(negedge clk) chk(oe, 8'h01);
        chk(bus, exp);
        en = 0;
        repeat (2) @(negedge clk);
        chk(oe, 8'h00);
    endtask
    initial begin
        #200000 err_total++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 0;
        for (s = 0; s < 4; s++) rd(2'(s), 8'h00);
        for (k = 0; k < 8; k++) begin
            s = k % 2;
            dir[s] = $random(seed) & 8'hFF;
            lat[s] = $random(seed) & 8'hFF;
            wr(2'(2 * s + 1), 8'h00);
            wr(2'(2 * s), 8'(dir[s]));
            rd(2'(2 * s), 8'(dir[s]));
            wr(2'(2 * s + 1), 8'hC4);
            wr(2'(2 * s), 8'(lat[s]));
            pa = 8'($random(seed));
            pb = 8'($random(seed));
            rd(2'(2 * s + 1), 8'h04);
            rd(2'(2 * s), pexp(s));
            chk(s ? pb_e : pa_e, 8'(dir[s]));
            chk(s ? pb_o & pb_e : pa_o & pa_e, 8'(dir[s] & lat[s]));
        end
        for (k = 0; k < 3; k++) begin
            {cs_n, cs_h} = k ? 3'(k) : 3'h7;
            wr(2'h1, 8'h3F);
        end
        {cs_n, cs_h} = 3'h3;
        rd(2'h1, 8'h04);
        wr(2'h1, 8'h07);
        wr(2'h3, 8'h07);
        {e_a, e_b} = 2'h3;
        repeat (4) @(negedge clk);
        chk({zq, qa, qb, irq_n}, 8'h06);
        rd(2'h1, 8'h87);
        rd(2'h0, pexp(0));
        chk({qa, qb, irq_n}, 8'h02);
        rd(2'h2, pexp(1));
        chk({qa, qb, irq_n}, 8'h01);
        {e_a, ln} = 3'h2;
        repeat (4) @(negedge clk);
        chk({qa, irq_n}, 8'h01);
        rd(2'h1, 8'h47);
        wr(2'h3, 8'h3C);
        chk({lb, lbe, lae, la}, 8'h0D);
        wr(2'h3, 8'h34);
        chk({lb, lbe}, 8'h01);
        wr(2'h1, 8'h2C);
        rd(2'h0, pa);
        chk({la, lae}, 8'h01);
        @(negedge clk) clr_n = 0;
        @(negedge clk) clr_n = 1;
        chk(pb_e | pb_o, 8'h00);
        rd(2'h3, 8'h00);
        final_report;
    end
endmodule // dual_port_parallel_adapter_tb_top
`default_nettype wire
